// ### rtl/mcr_pkg.sv
// Constants shared by the meter calibration register bank
`default_nettype none
package mcr_pkg;
   //------------------------------------------------------------
   // Register port
   //------------------------------------------------------------
   localparam int ADDR_W = 12;
   localparam logic [11:0] OFF_EFF_ACT_SHIFT = 12'h024;
   localparam logic [11:0] OFF_EFF_REACT_GAIN = 12'h025;
   localparam logic [11:0] OFF_EFF_REACT_GAIN_HI = 12'h026;
   localparam logic [11:0] OFF_EFF_REACT_SHIFT = 12'h027;
   localparam logic [11:0] CAL_BASE = 12'h028;
   localparam logic [11:0] CAL_LAST = 12'h048;
   localparam int CAL_BYTES = 33;
   //------------------------------------------------------------
   // Calibration byte indexes, relative to the bank base
   //------------------------------------------------------------
   localparam int IDX_PHASE_LO = 'h28 - 'h28;
   localparam int IDX_PHASE_HI = 'h29 - 'h28;
   localparam int IDX_VOLT_GAIN = 'h2a - 'h28;
   localparam int IDX_IRMS_GAIN_LO = 'h2c - 'h28;
   localparam int IDX_IRMS_GAIN_HI = 'h2e - 'h28;
   localparam int IDX_ACT_PWR_LO = 'h30 - 'h28;
   localparam int IDX_ACT_PWR_HI = 'h32 - 'h28;
   localparam int IDX_ACT_EGAIN_LO = 'h34 - 'h28;
   localparam int IDX_ACT_EGAIN_HI = 'h36 - 'h28;
   localparam int IDX_ACT_SHIFT_LO = 'h38 - 'h28;
   localparam int IDX_ACT_SHIFT_HI = 'h39 - 'h28;
   localparam int IDX_REACT_PWR_LO = 'h3a - 'h28;
   localparam int IDX_REACT_PWR_HI = 'h3c - 'h28;
   localparam int IDX_REACT_EGAIN_LO = 'h3e - 'h28;
   localparam int IDX_REACT_EGAIN_HI = 'h40 - 'h28;
   localparam int IDX_REACT_SHIFT_LO = 'h42 - 'h28;
   localparam int IDX_REACT_SHIFT_HI = 'h43 - 'h28;
   localparam int IDX_METER_CONST = 'h44 - 'h28;
   localparam int IDX_PULSE_MS = 'h46 - 'h28;
   localparam int IDX_NO_LOAD = 'h47 - 'h28;
   localparam int IDX_CYCLE_EXP = 'h48 - 'h28;
   //------------------------------------------------------------
   // Reset values and limits
   //------------------------------------------------------------
   localparam logic [7:0] CYCLE_EXP_RESET = 8'h04;
   localparam logic [7:0] CYCLE_EXP_MAX = 8'h0f;
   localparam logic [7:0] PULSE_MS_RESET = 8'h0a;
   localparam logic [7:0] PULSE_MS_MAX = 8'h41;
   localparam logic [15:0] REGION_SWITCH_LEVEL = 16'h1388;
   //------------------------------------------------------------
   // Timing
   //------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int MS_TICK_NS = 1000000;
   localparam int MS_TICK_CYCLES = MS_TICK_NS / CLK_PERIOD_NS;
endpackage
`default_nettype wire

// ### rtl/mcr_regs.sv
// Meter calibration register bank with region copies and energy pulse timing
//
// Functional notes
// - Read-only effective active shift at 0x024
// - Read-only effective reactive gain at 0x025
// - Read-only effective reactive shift at 0x027
// - Writable low-region phase compensation at 0x028
// - Writable high-region phase compensation at 0x029
// - One voltage RMS gain at 0x02A
// - Current RMS gains low 0x02C, high 0x02E
// - Active power gains low 0x030, high 0x032
// - Active energy gains low 0x034, high 0x036
// - Active shift counts low 0x038, high 0x039
// - Reactive power gains low 0x03A, high 0x03C
// - Reactive energy gains low 0x03E, high 0x040
// - Reactive shift counts at 0x042, 0x043
// - Energy pulse lasts programmed milliseconds, max 65
// - No accumulation below low-region no-load threshold
// - Computation cycle is 2^n line cycles
// - Cycle exponent resets to 4
// - Host region bit: one low, zero high
// - Force bit bypasses automatic region selection
`timescale 1ns/10ps
`default_nettype none

//------------------------------------------------------------
// Energy pulse generator
//------------------------------------------------------------
module mcr_pulse_gen #(
   parameter int MS_CYCLES = mcr_pkg::MS_TICK_CYCLES
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // Request and width
   input wire logic start,
   input wire logic [7:0] widthMs,
   // Pulse out
   output logic pulse
);
   typedef struct packed {
      logic active;
      logic [16:0] cycleCnt;
      logic [7:0] msLeft;
   } mcr_pulse_t;

   mcr_pulse_t st;
   mcr_pulse_t next_st;
   logic [7:0] clampWidth;
   logic msDone;

   always_comb begin
      next_st = st;
      clampWidth = widthMs;
      if (widthMs == 8'h00) begin
         clampWidth = 8'h01;
      end else if (widthMs > mcr_pkg::PULSE_MS_MAX) begin
         clampWidth = mcr_pkg::PULSE_MS_MAX;
      end
      msDone = (st.cycleCnt == 17'(MS_CYCLES - 1));
      if (!st.active) begin
         if (start) begin
            next_st.active = 1'b1;
            next_st.cycleCnt = 17'h0;
            next_st.msLeft = clampWidth;
         end
      end else if (msDone) begin
         // Millisecond tick; requests while active are dropped
         next_st.cycleCnt = 17'h0;
         next_st.msLeft = st.msLeft - 8'h01;
         if (st.msLeft == 8'h01) begin
            next_st.active = 1'b0;
         end
      end else begin
         next_st.cycleCnt = st.cycleCnt + 17'h1;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign pulse = st.active;

   pulse_load_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      (start && !st.active) |=> (st.active && st.msLeft == $past(clampWidth)))
      else $error("pulse width not loaded");
   pulse_norestart_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      (st.active && !msDone) |=> (st.active && $stable(st.msLeft)))
      else $error("pulse restarted or cut short");
   pulse_end_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      (st.active && msDone && st.msLeft == 8'h01) |=> !st.active)
      else $error("pulse did not end");
endmodule

//------------------------------------------------------------
// Register bank top
//------------------------------------------------------------
module mcr_regs #(
   parameter int MS_CYCLES = mcr_pkg::MS_TICK_CYCLES
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // Byte register port from the command parser
   input wire logic [11:0] regAddr,
   input wire logic regWrite,
   input wire logic [7:0] regWrData,
   input wire logic regRead,
   output logic [7:0] regRdData,
   output logic regRdValid,
   // Region control and measurement
   input wire logic forceRegion,
   input wire logic hostRegionChoice,
   input wire logic [15:0] currentRmsIndication,
   input wire logic lineCycleTick,
   // Energy pulse requests
   input wire logic activePulseRequest,
   input wire logic reactivePulseRequest,
   // Effective calibration to the datapath
   output logic regionLow,
   output logic computeCycleEnd,
   output logic accumulateEnable,
   output logic [7:0] phaseComp,
   output logic [15:0] voltageRmsGain,
   output logic [15:0] currentRmsGain,
   output logic [15:0] activePowerGain,
   output logic [15:0] reactivePowerGain,
   output logic [15:0] activeEnergyGain,
   output logic [7:0] effActiveEnergyShift,
   output logic [15:0] effReactiveEnergyGain,
   output logic [7:0] effReactiveEnergyShift,
   output logic [15:0] impulsesPerKwh,
   // Energy pulses
   output logic activeEnergyPulse,
   output logic reactiveEnergyPulse
);
   typedef struct packed {
      logic [mcr_pkg::CAL_BYTES-1:0][7:0] cal;
      logic regionLow;
      logic loadPending;
      logic cycleEnd;
      logic [15:0] lineCount;
      logic accumulate;
      logic [7:0] phaseComp;
      logic [15:0] irmsGain;
      logic [15:0] actPwrGain;
      logic [15:0] reactPwrGain;
      logic [15:0] actEGain;
      logic [7:0] actShift;
      logic [15:0] reactEGain;
      logic [7:0] reactShift;
      logic [7:0] rdData;
      logic rdValid;
   } mcr_state_t;

   mcr_state_t st;
   mcr_state_t next_st;
   logic [11:0] calOff;
   logic inCal;
   logic [7:0] cycleExp;
   logic [16:0] lineTarget;
   logic doUpdate;
   logic selLow;

   function automatic logic [15:0] calWord(input logic [mcr_pkg::CAL_BYTES-1:0][7:0] c,
                                           input int idx);
      calWord = {c[idx + 1], c[idx]};
   endfunction

   always_comb begin
      next_st = st;
      calOff = regAddr - mcr_pkg::CAL_BASE;
      inCal = (regAddr >= mcr_pkg::CAL_BASE) && (regAddr <= mcr_pkg::CAL_LAST);
      // Calibration writes, one byte each
      if (regWrite && inCal) begin
         next_st.cal[calOff[5:0]] = regWrData;
      end
      // Byte reads; unmapped reads return zero
      next_st.rdValid = regRead;
      next_st.rdData = 8'h00;
      if (regRead) begin
         if (inCal) begin
            next_st.rdData = st.cal[calOff[5:0]];
         end else if (regAddr == mcr_pkg::OFF_EFF_ACT_SHIFT) begin
            next_st.rdData = st.actShift;
         end else if (regAddr == mcr_pkg::OFF_EFF_REACT_GAIN) begin
            next_st.rdData = st.reactEGain[7:0];
         end else if (regAddr == mcr_pkg::OFF_EFF_REACT_GAIN_HI) begin
            next_st.rdData = st.reactEGain[15:8];
         end else if (regAddr == mcr_pkg::OFF_EFF_REACT_SHIFT) begin
            next_st.rdData = st.reactShift;
         end
      end
      // Computation cycle of 2^n line cycles
      cycleExp = st.cal[mcr_pkg::IDX_CYCLE_EXP];
      if (cycleExp > mcr_pkg::CYCLE_EXP_MAX) begin
         cycleExp = mcr_pkg::CYCLE_EXP_MAX;
      end
      lineTarget = 17'h1 << cycleExp[3:0];
      next_st.cycleEnd = 1'b0;
      doUpdate = st.loadPending;
      if (lineCycleTick) begin
         if (({1'b0, st.lineCount} + 17'h1) >= lineTarget) begin
            next_st.lineCount = 16'h0;
            next_st.cycleEnd = 1'b1;
            doUpdate = 1'b1;
         end else begin
            next_st.lineCount = st.lineCount + 16'h1;
         end
      end
      // Region choice: host bit when forced, else from current RMS
      if (forceRegion) begin
         selLow = hostRegionChoice;
      end else begin
         selLow = (currentRmsIndication < mcr_pkg::REGION_SWITCH_LEVEL);
      end
      // All copies switch together at the boundary
      if (doUpdate) begin
         next_st.loadPending = 1'b0;
         next_st.regionLow = selLow;
         if (selLow) begin
            next_st.phaseComp = st.cal[mcr_pkg::IDX_PHASE_LO];
            next_st.irmsGain = calWord(st.cal, mcr_pkg::IDX_IRMS_GAIN_LO);
            next_st.actPwrGain = calWord(st.cal, mcr_pkg::IDX_ACT_PWR_LO);
            next_st.reactPwrGain = calWord(st.cal, mcr_pkg::IDX_REACT_PWR_LO);
            next_st.actEGain = calWord(st.cal, mcr_pkg::IDX_ACT_EGAIN_LO);
            next_st.actShift = st.cal[mcr_pkg::IDX_ACT_SHIFT_LO];
            next_st.reactEGain = calWord(st.cal, mcr_pkg::IDX_REACT_EGAIN_LO);
            next_st.reactShift = st.cal[mcr_pkg::IDX_REACT_SHIFT_LO];
         end else begin
            next_st.phaseComp = st.cal[mcr_pkg::IDX_PHASE_HI];
            next_st.irmsGain = calWord(st.cal, mcr_pkg::IDX_IRMS_GAIN_HI);
            next_st.actPwrGain = calWord(st.cal, mcr_pkg::IDX_ACT_PWR_HI);
            next_st.reactPwrGain = calWord(st.cal, mcr_pkg::IDX_REACT_PWR_HI);
            next_st.actEGain = calWord(st.cal, mcr_pkg::IDX_ACT_EGAIN_HI);
            next_st.actShift = st.cal[mcr_pkg::IDX_ACT_SHIFT_HI];
            next_st.reactEGain = calWord(st.cal, mcr_pkg::IDX_REACT_EGAIN_HI);
            next_st.reactShift = st.cal[mcr_pkg::IDX_REACT_SHIFT_HI];
         end
      end
      // No-load gate applies in the low region only
      next_st.accumulate = !(st.regionLow &&
         (currentRmsIndication < {8'h00, st.cal[mcr_pkg::IDX_NO_LOAD]}));
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         st <= '0;
         st.cal[mcr_pkg::IDX_CYCLE_EXP] <= mcr_pkg::CYCLE_EXP_RESET;
         st.cal[mcr_pkg::IDX_PULSE_MS] <= mcr_pkg::PULSE_MS_RESET;
         st.loadPending <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   //------------------------------------------------------------
   // Energy pulses, gated by the no-load state
   //------------------------------------------------------------
   mcr_pulse_gen #(.MS_CYCLES(MS_CYCLES)) actPulse (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .start(activePulseRequest && st.accumulate),
      .widthMs(st.cal[mcr_pkg::IDX_PULSE_MS]),
      .pulse(activeEnergyPulse)
   );

   mcr_pulse_gen #(.MS_CYCLES(MS_CYCLES)) reactPulse (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .start(reactivePulseRequest && st.accumulate),
      .widthMs(st.cal[mcr_pkg::IDX_PULSE_MS]),
      .pulse(reactiveEnergyPulse)
   );

   assign regRdData = st.rdData;
   assign regRdValid = st.rdValid;
   assign regionLow = st.regionLow;
   assign computeCycleEnd = st.cycleEnd;
   assign accumulateEnable = st.accumulate;
   assign phaseComp = st.phaseComp;
   assign voltageRmsGain = calWord(st.cal, mcr_pkg::IDX_VOLT_GAIN);
   assign currentRmsGain = st.irmsGain;
   assign activePowerGain = st.actPwrGain;
   assign reactivePowerGain = st.reactPwrGain;
   assign activeEnergyGain = st.actEGain;
   assign effActiveEnergyShift = st.actShift;
   assign effReactiveEnergyGain = st.reactEGain;
   assign effReactiveEnergyShift = st.reactShift;
   assign impulsesPerKwh = calWord(st.cal, mcr_pkg::IDX_METER_CONST);

   //------------------------------------------------------------
   // Checks
   //------------------------------------------------------------
   eff_copies_stable_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      !doUpdate |=> $stable({st.regionLow, st.actShift, st.reactEGain, st.reactShift, st.irmsGain}))
      else $error("effective copy changed off boundary");
   eff_react_gain_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      (st.cycleEnd && $stable(st.cal)) |-> (st.reactEGain == (st.regionLow ?
         calWord(st.cal, mcr_pkg::IDX_REACT_EGAIN_LO) : calWord(st.cal, mcr_pkg::IDX_REACT_EGAIN_HI))))
      else $error("wrong reactive gain copy");
   eff_react_shift_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      (st.cycleEnd && $stable(st.cal)) |-> (st.reactShift == (st.regionLow ?
         st.cal[mcr_pkg::IDX_REACT_SHIFT_LO] : st.cal[mcr_pkg::IDX_REACT_SHIFT_HI])))
      else $error("wrong reactive shift copy");
   read_act_shift_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      (regRead && regAddr == mcr_pkg::OFF_EFF_ACT_SHIFT) |=> (regRdValid && regRdData == $past(st.actShift)))
      else $error("effective active shift read wrong");
   write_phase_lo_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      (regWrite && regAddr == mcr_pkg::CAL_BASE) |=> (st.cal[mcr_pkg::IDX_PHASE_LO] == $past(regWrData)))
      else $error("phase compensation write lost");
   force_region_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      (doUpdate && forceRegion) |=> (regionLow == $past(hostRegionChoice)))
      else $error("forced region not applied");
   no_load_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      (st.regionLow && currentRmsIndication < {8'h00, st.cal[mcr_pkg::IDX_NO_LOAD]}) |=> !accumulateEnable)
      else $error("accumulation below no-load threshold");
   cycle_len_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      (lineCycleTick && ({1'b0, st.lineCount} + 17'h1) == lineTarget) |=> (computeCycleEnd && st.lineCount == 16'h0))
      else $error("computation cycle length wrong");
endmodule

`default_nettype wire

// ### dv/mcr_host_model.sv
// Calibration host model driving the byte register port and region control
`timescale 1ns/10ps
`default_nettype none

module mcr_host_model (
   // Clock
   input wire logic sys_clk,
   // Register port
   output logic [11:0] regAddr,
   output logic regWrite,
   output logic [7:0] regWrData,
   output logic regRead,
   input wire logic [7:0] regRdData,
   input wire logic regRdValid,
   // Region control
   output logic forceRegion,
   output logic hostRegionChoice
);
   initial begin
      regAddr = 12'h000;
      regWrite = 1'b0;
      regWrData = 8'h00;
      regRead = 1'b0;
      forceRegion = 1'b0;
      hostRegionChoice = 1'b0;
   end

   //------------------------------------------------------------
   // Byte access, one idle cycle after each
   //------------------------------------------------------------
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      regAddr = a;
      regWrData = d;
      regWrite = 1'b1;
      @(negedge sys_clk);
      regWrite = 1'b0;
      // Idle bus shows no stale address or data
      regAddr = ~a;
      regWrData = ~d;
   endtask

   task automatic wr16(input logic [11:0] a, input logic [15:0] d);
      wr(a, d[7:0]);
      wr(12'(a + 12'h001), d[15:8]);
   endtask

   task automatic rd(input logic [11:0] a, output logic [7:0] d);
      @(negedge sys_clk);
      regAddr = a;
      regRead = 1'b1;
      @(negedge sys_clk);
      d = (regRdValid === 1'b1) ? regRdData : 8'hxx;
      regRead = 1'b0;
      regAddr = ~a;
   endtask

   //------------------------------------------------------------
   // Region control, one selects the low region
   //------------------------------------------------------------
   task automatic setRegion(input logic forceIt, input logic lowChoice);
      forceRegion = forceIt;
      hostRegionChoice = lowChoice;
   endtask
endmodule

`default_nettype wire

// ### dv/tb_top.sv
// Self-checking bench of the meter calibration register bank
`timescale 1ns/10ps
`default_nettype none

`define CHECK(what, expv, gotv) begin nChecks++; if ((gotv) !== (expv)) begin mismatches++; \
   $display("FAIL %s expected %h seen %h", what, expv, gotv); end end

module tb_top;
   logic sys_clk, resetn, regWrite, regRead, regRdValid, forceRegion, hostRegionChoice;
   logic [11:0] regAddr;
   logic [7:0] regWrData, regRdData, phaseComp, effActiveEnergyShift, effReactiveEnergyShift;
   logic [15:0] currentRmsIndication, voltageRmsGain, currentRmsGain, activePowerGain;
   logic [15:0] reactivePowerGain, activeEnergyGain, effReactiveEnergyGain, impulsesPerKwh;
   logic lineCycleTick, activePulseRequest, reactivePulseRequest, regionLow, computeCycleEnd;
   logic accumulateEnable, activeEnergyPulse, reactiveEnergyPulse;
   logic [7:0] d0, d1;
   int mismatches = 0;
   int nChecks = 0;
   int cycles = 0;

   mcr_host_model i_host (.sys_clk(sys_clk), .regAddr(regAddr), .regWrite(regWrite),
      .regWrData(regWrData), .regRead(regRead), .regRdData(regRdData), .regRdValid(regRdValid),
      .forceRegion(forceRegion), .hostRegionChoice(hostRegionChoice));

   mcr_regs #(.MS_CYCLES(4)) i_dut (.sys_clk(sys_clk), .resetn(resetn), .regAddr(regAddr),
      .regWrite(regWrite), .regWrData(regWrData), .regRead(regRead), .regRdData(regRdData),
      .regRdValid(regRdValid), .forceRegion(forceRegion), .hostRegionChoice(hostRegionChoice),
      .currentRmsIndication(currentRmsIndication), .lineCycleTick(lineCycleTick),
      .activePulseRequest(activePulseRequest), .reactivePulseRequest(reactivePulseRequest),
      .regionLow(regionLow), .computeCycleEnd(computeCycleEnd), .accumulateEnable(accumulateEnable),
      .phaseComp(phaseComp), .voltageRmsGain(voltageRmsGain), .currentRmsGain(currentRmsGain),
      .activePowerGain(activePowerGain), .reactivePowerGain(reactivePowerGain),
      .activeEnergyGain(activeEnergyGain), .effActiveEnergyShift(effActiveEnergyShift),
      .effReactiveEnergyGain(effReactiveEnergyGain), .effReactiveEnergyShift(effReactiveEnergyShift),
      .impulsesPerKwh(impulsesPerKwh), .activeEnergyPulse(activeEnergyPulse),
      .reactiveEnergyPulse(reactiveEnergyPulse));

   //------------------------------------------------------------
   // Clock, timeout and closing report
   //------------------------------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   task automatic wrapUp();
      $display("checks %0d mismatches %0d", nChecks, mismatches);
      if (mismatches == 0 && nChecks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         $display("FAIL timeout expected done seen hang");
         wrapUp();
      end
   end

   //------------------------------------------------------------
   // Expected calibration byte at bank index
   //------------------------------------------------------------
   function automatic logic [7:0] cal(input int i);
      case (i)
         28: return 8'hb0;
         29: return 8'h04;
         30: return 8'h03;
         31: return 8'h20;
         32: return 8'h01;
         default: return 8'(i * 7 + 17);
      endcase
   endfunction

   task automatic tick(input logic expEnd);
      @(negedge sys_clk);
      lineCycleTick = 1'b1;
      @(negedge sys_clk);
      lineCycleTick = 1'b0;
      `CHECK("computeCycleEnd", expEnd, computeCycleEnd)
      @(negedge sys_clk);
      `CHECK("computeCycleEnd one cycle", 1'b0, computeCycleEnd)
   endtask

   task automatic checkEff(input int lo);
      logic [7:0] a, b, c;
      int o;
      o = lo ? 0 : 1;
      `CHECK("regionLow", 1'(lo), regionLow)
      `CHECK("phaseComp", cal(o), phaseComp)
      `CHECK("currentRmsGain", {cal(5 + 2 * o), cal(4 + 2 * o)}, currentRmsGain)
      `CHECK("activePowerGain", {cal(9 + 2 * o), cal(8 + 2 * o)}, activePowerGain)
      `CHECK("activeEnergyGain", {cal(13 + 2 * o), cal(12 + 2 * o)}, activeEnergyGain)
      `CHECK("reactivePowerGain", {cal(19 + 2 * o), cal(18 + 2 * o)}, reactivePowerGain)
      `CHECK("effActiveEnergyShift", cal(16 + o), effActiveEnergyShift)
      `CHECK("effReactiveEnergyGain", {cal(23 + 2 * o), cal(22 + 2 * o)}, effReactiveEnergyGain)
      `CHECK("effReactiveEnergyShift", cal(26 + o), effReactiveEnergyShift)
      i_host.rd(12'h024, a);
      `CHECK("read 0x024", cal(16 + o), a)
      i_host.rd(12'h025, b);
      i_host.rd(12'h026, c);
      `CHECK("read 0x025", {cal(23 + 2 * o), cal(22 + 2 * o)}, {c, b})
      i_host.rd(12'h027, a);
      `CHECK("read 0x027", cal(26 + o), a)
   endtask

   task automatic pulseRun(input int expLen);
      int nAct;
      int nReact;
      nAct = 0;
      nReact = 0;
      for (int i = 0; i < 300; i++) begin
         @(negedge sys_clk);
         // Second request lands while the pulse is high
         activePulseRequest = (i == 0 || i == 4);
         reactivePulseRequest = (i == 0 || i == 4);
         nAct += (activeEnergyPulse === 1'b1);
         nReact += (reactiveEnergyPulse === 1'b1);
      end
      `CHECK("active pulse cycles", expLen, nAct)
      `CHECK("reactive pulse cycles", expLen, nReact)
   endtask

   //------------------------------------------------------------
   // Main sequence
   //------------------------------------------------------------
   initial begin
      resetn = 1'b0;
      currentRmsIndication = 16'h0000;
      lineCycleTick = 1'b0;
      activePulseRequest = 1'b0;
      reactivePulseRequest = 1'b0;
      repeat (8) @(negedge sys_clk);
      resetn = 1'b1;

      i_host.rd(12'h048, d0);
      `CHECK("reset 0x048", 8'h04, d0)
      i_host.rd(12'h046, d0);
      `CHECK("reset 0x046", 8'h0a, d0)
      i_host.wr(12'h024, 8'hff);
      i_host.wr(12'h027, 8'hff);
      i_host.wr(12'h100, 8'hff);
      i_host.rd(12'h024, d0);
      `CHECK("read-only 0x024", 8'h00, d0)
      i_host.rd(12'h027, d0);
      `CHECK("read-only 0x027", 8'h00, d0)
      i_host.rd(12'h100, d0);
      `CHECK("unmapped 0x100", 8'h00, d0)
      $display("test reset_and_readonly done");

      for (int i = 0; i < 33; i++) if (i != 28 && i != 29) i_host.wr(12'(12'h028 + i), cal(i));
      i_host.wr16(12'h044, 16'd1200);
      for (int i = 0; i < 33; i++) begin
         i_host.rd(12'(12'h028 + i), d1);
         `CHECK("calibration byte", cal(i), d1)
      end
      `CHECK("voltageRmsGain", {cal(3), cal(2)}, voltageRmsGain)
      `CHECK("impulsesPerKwh", 16'h04b0, impulsesPerKwh)
      $display("test write_readback done");

      i_host.setRegion(1'b1, 1'b1);
      tick(1'b0);
      tick(1'b1);
      checkEff(1);
      i_host.setRegion(1'b1, 1'b0);
      tick(1'b0);
      checkEff(1);
      tick(1'b1);
      checkEff(0);
      i_host.setRegion(1'b0, 1'b1);
      currentRmsIndication = 16'h1388;
      tick(1'b0);
      tick(1'b1);
      checkEff(0);
      currentRmsIndication = 16'h1387;
      tick(1'b0);
      tick(1'b1);
      checkEff(1);
      $display("test region_copies done");

      `CHECK("accumulateEnable", 1'b1, accumulateEnable)
      pulseRun(12);
      i_host.wr(12'h046, 8'h50);
      pulseRun(260);
      i_host.wr(12'h046, 8'h00);
      pulseRun(4);
      $display("test energy_pulses done");

      currentRmsIndication = 16'h001f;
      repeat (2) @(negedge sys_clk);
      `CHECK("accumulateEnable below", 1'b0, accumulateEnable)
      pulseRun(0);
      currentRmsIndication = 16'h0020;
      repeat (2) @(negedge sys_clk);
      `CHECK("accumulateEnable at", 1'b1, accumulateEnable)
      $display("test no_load done");
      wrapUp();
   end
endmodule

`default_nettype wire
